// file: obsrp_pkg.sv
// package: option byte store constants, types and register map
package obsrp_pkg;

  localparam logic [15:0] ADDR_READOUT_PROTECT   = 16'h4800;
  localparam logic [15:0] ADDR_ALT_MUX_P2        = 16'h4813;
  localparam logic [15:0] ADDR_ALT_MUX_P2_INV    = 16'h4814;
  localparam logic [15:0] ADDR_MISC_OPT0         = 16'h4815;
  localparam logic [15:0] ADDR_MISC_OPT0_INV     = 16'h4816;
  localparam logic [15:0] ADDR_RESERVED_OPTION   = 16'h487D;
  localparam logic [15:0] ADDR_BOOTLOADER_TRUE   = 16'h487E;
  localparam logic [15:0] ADDR_BOOTLOADER_INV    = 16'h487F;

  // data eeprom window holding the option bytes
  localparam logic [15:0] ADDR_EEPROM_BASE       = 16'h4000;
  localparam logic [15:0] ADDR_EEPROM_LAST       = 16'h4BFF;

  localparam logic [7:0]  RST_READOUT_PROTECT    = 8'h00;
  localparam logic [7:0]  RST_TRUE_COPY          = 8'h00;
  localparam logic [7:0]  RST_COMPLEMENT_COPY    = 8'hFF;
  localparam logic [7:0]  RST_RESERVED           = 8'h00;
  localparam logic [7:0]  CODE_PROTECT_ON        = 8'hAA;

  localparam int          NUM_PAIRS              = 3;

  typedef enum logic [2:0] {
    OBS_LOAD  = 3'b001,
    OBS_CHECK = 3'b010,
    OBS_RUN   = 3'b100
  } obs_state_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } obs_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        err;
  } obs_rsp_t;

  typedef struct packed {
    logic [7:0]  altMuxP2;
    logic [7:0]  miscOpt0;
    logic [7:0]  bootOption;
  } obs_opts_t;

endpackage

// file: obsrp_option_store.sv
// option byte store with read-out protection control
`timescale 1ns/1ps
module obsrp_option_store
  import obsrp_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire obs_req_t  dbgReq,
  output obs_rsp_t       dbgRsp,
  input  wire obs_req_t  appReq,
  output obs_rsp_t       appRsp,
  input  wire logic      memWriteProtect,
  output logic           memAccessBlock,
  output logic           readoutProtect,
  output obs_opts_t      appliedOpts,
  output logic [NUM_PAIRS-1:0] optInvalid,
  output logic           optLoaded
);

  typedef struct packed {
    obs_state_t            state;
    logic [7:0]            protByte;
    logic [NUM_PAIRS-1:0][7:0] trueCopy;
    logic [NUM_PAIRS-1:0][7:0] compCopy;
    logic [7:0]            rsvdByte;
    obs_rsp_t              dbgRsp;
    obs_rsp_t              appRsp;
    obs_opts_t             opts;
    logic [NUM_PAIRS-1:0]  invalid;
    logic                  protOn;
    logic                  block;
    logic                  loaded;
  } obs_regs_t;

  obs_regs_t cur_ff;
  obs_regs_t nxt_cur;

  logic [15:0] pairTrue [NUM_PAIRS];
  logic [15:0] pairComp [NUM_PAIRS];
  logic [NUM_PAIRS-1:0] mismatch;

  assign pairTrue[0] = ADDR_ALT_MUX_P2;
  assign pairComp[0] = ADDR_ALT_MUX_P2_INV;
  assign pairTrue[1] = ADDR_MISC_OPT0;
  assign pairComp[1] = ADDR_MISC_OPT0_INV;
  assign pairTrue[2] = ADDR_BOOTLOADER_TRUE;
  assign pairComp[2] = ADDR_BOOTLOADER_INV;

  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : gPair
      assign mismatch[g] = cur_ff.trueCopy[g] != ~cur_ff.compCopy[g];
    end
  endgenerate

  function automatic logic inEeprom(input logic [15:0] a);
    inEeprom = (a >= ADDR_EEPROM_BASE) && (a <= ADDR_EEPROM_LAST);
  endfunction

  // reads one option byte; unmapped eeprom locations read zero
  function automatic logic [7:0] readByte(input obs_regs_t r,
                                          input logic [15:0] a);
    readByte = 8'h00;
    if (a == ADDR_READOUT_PROTECT) readByte = r.protByte;
    if (a == ADDR_RESERVED_OPTION) readByte = r.rsvdByte;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (a == pairTrue[i]) readByte = r.trueCopy[i];
      if (a == pairComp[i]) readByte = r.compCopy[i];
    end
  endfunction

  always_comb begin
    logic dbgOk;
    logic appOk;
    dbgOk = 1'b0;
    appOk = 1'b0;
    nxt_cur = cur_ff;
    nxt_cur.dbgRsp = '0;
    nxt_cur.appRsp = '0;
    case (cur_ff.state)
      OBS_LOAD: begin
        nxt_cur.state = OBS_CHECK;
      end
      OBS_CHECK: begin
        // options applied only from a consistent pair
        for (int i = 0; i < NUM_PAIRS; i++) begin
          nxt_cur.invalid[i] = mismatch[i];
        end
        nxt_cur.opts.altMuxP2 = mismatch[0] ? RST_TRUE_COPY
                                            : cur_ff.trueCopy[0];
        nxt_cur.opts.miscOpt0 = mismatch[1] ? RST_TRUE_COPY
                                            : cur_ff.trueCopy[1];
        nxt_cur.opts.bootOption = mismatch[2] ? RST_TRUE_COPY
                                            : cur_ff.trueCopy[2];
        nxt_cur.protOn = cur_ff.protByte == CODE_PROTECT_ON;
        nxt_cur.loaded = 1'b1;
        nxt_cur.state  = OBS_RUN;
      end
      OBS_RUN: begin
        if (dbgReq.req) begin
          // protection refuses debug access, except the protection byte write below; memWriteProtect plays no part here
          dbgOk = inEeprom(dbgReq.addr) && !cur_ff.protOn;
          nxt_cur.dbgRsp.valid = 1'b1;
          nxt_cur.dbgRsp.err   = !dbgOk;
          if (dbgOk && !dbgReq.wr) begin
            nxt_cur.dbgRsp.rdata = readByte(cur_ff, dbgReq.addr);
          end
          // the protection byte itself stays writable so a debugger can
          // clear it; a real part would mass-erase here, not modelled
          if (dbgReq.wr && inEeprom(dbgReq.addr) &&
              dbgReq.addr == ADDR_READOUT_PROTECT) begin
            nxt_cur.protByte = dbgReq.wdata;
            // acts at once: reset restores factory bytes, so a reload
            // could never bring the protection code into force
            nxt_cur.protOn = dbgReq.wdata == CODE_PROTECT_ON;
            nxt_cur.dbgRsp.err = 1'b0;
          end
          if (dbgOk && dbgReq.wr) begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
              if (dbgReq.addr == pairTrue[i])
                nxt_cur.trueCopy[i] = dbgReq.wdata;
              if (dbgReq.addr == pairComp[i])
                nxt_cur.compCopy[i] = dbgReq.wdata;
            end
          end
        end else if (appReq.req) begin
          appOk = inEeprom(appReq.addr) &&
                  !(appReq.wr && (memWriteProtect ||
                    appReq.addr == ADDR_READOUT_PROTECT));
          nxt_cur.appRsp.valid = 1'b1;
          nxt_cur.appRsp.err   = !appOk;
          if (appOk && !appReq.wr) begin
            nxt_cur.appRsp.rdata = readByte(cur_ff, appReq.addr);
          end
          if (appOk && appReq.wr) begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
              if (appReq.addr == pairTrue[i])
                nxt_cur.trueCopy[i] = appReq.wdata;
              if (appReq.addr == pairComp[i])
                nxt_cur.compCopy[i] = appReq.wdata;
            end
          end
        end
        // new option pair bytes never take effect: the load runs only after reset, which restores factory bytes
      end
      default: begin
        nxt_cur.state = OBS_LOAD;
      end
    endcase
    // block follows protection alone, write protection plays no part
    nxt_cur.block = nxt_cur.protOn;
  end

  // eeprom contents are nonvolatile in silicon; reset models factory state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff          <= '0;
      cur_ff.state    <= OBS_LOAD;
      cur_ff.protByte <= RST_READOUT_PROTECT;
      cur_ff.rsvdByte <= RST_RESERVED;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        cur_ff.trueCopy[i] <= RST_TRUE_COPY;
        cur_ff.compCopy[i] <= RST_COMPLEMENT_COPY;
      end
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign dbgRsp         = cur_ff.dbgRsp;
  assign appRsp         = cur_ff.appRsp;
  assign memAccessBlock = cur_ff.block;
  assign readoutProtect = cur_ff.protOn;
  assign appliedOpts    = cur_ff.opts;
  assign optInvalid     = cur_ff.invalid;
  assign optLoaded      = cur_ff.loaded;

endmodule

// file: obsrp_option_store_asserts.sv
// port checks for the option byte store
`timescale 1ns/1ps
module obsrp_option_store_asserts
  import obsrp_pkg::*;
(
  input wire logic      mclk,
  input wire logic      rst_n,
  input wire obs_req_t  dbgReq,
  input wire obs_rsp_t  dbgRsp,
  input wire obs_req_t  appReq,
  input wire obs_rsp_t  appRsp,
  input wire logic      memWriteProtect,
  input wire logic      memAccessBlock,
  input wire logic      readoutProtect,
  input wire obs_opts_t appliedOpts,
  input wire logic [NUM_PAIRS-1:0] optInvalid,
  input wire logic      optLoaded
);
  default clocking dck @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence sDbg; dbgReq.req && optLoaded; endsequence
  // debug wins a tie, so only a lone app request counts
  sequence sApp; appReq.req && !dbgReq.req && optLoaded; endsequence
  a_dbg_answer:
    assert property (sDbg |=> dbgRsp.valid) else $error("no answer");
  a_app_protect_refused:
    assert property (sApp ##0 (appReq.wr &&
      appReq.addr == ADDR_READOUT_PROTECT) |=> appRsp.valid && appRsp.err)
    else $error("app protect write taken");
  a_outside_eeprom:
    assert property (sDbg ##0 (dbgReq.addr < ADDR_EEPROM_BASE ||
      dbgReq.addr > ADDR_EEPROM_LAST) |=> dbgRsp.err)
    else $error("outside access taken");
  a_protect_blocks:
    assert property (sDbg ##0 (readoutProtect && !(dbgReq.wr &&
      dbgReq.addr == ADDR_READOUT_PROTECT)) |=> dbgRsp.err)
    else $error("protected access taken");
  a_block_level:
    assert property (readoutProtect |-> memAccessBlock)
    else $error("block low");
  a_opts_hold:
    assert property (optLoaded && $past(optLoaded) |->
      $stable(appliedOpts))
    else $error("options moved");
  a_protect_hold:
    assert property ($past(optLoaded) && !$past(dbgReq.req &&
      dbgReq.wr && dbgReq.addr == ADDR_READOUT_PROTECT) |->
      $stable(readoutProtect))
    else $error("protection moved");
  a_protect_set:
    assert property (sDbg ##0 (dbgReq.wr &&
      dbgReq.addr == ADDR_READOUT_PROTECT) |=>
      readoutProtect == ($past(dbgReq.wdata) == CODE_PROTECT_ON))
    else $error("protection code not applied");
  a_bad_pair_zero:
    assert property (optInvalid[0] |-> appliedOpts.altMuxP2 == 8'h00)
    else $error("bad pair applied");
  a_factory_load:
    assert property ($rose(optLoaded) |-> optInvalid == '0)
    else $error("factory pair invalid");
endmodule
bind obsrp_option_store obsrp_option_store_asserts i_chk (.mclk, .rst_n,
  .dbgReq, .dbgRsp, .appReq, .appRsp, .memWriteProtect, .memAccessBlock,
  .readoutProtect, .appliedOpts, .optInvalid, .optLoaded);

// file: obsrp_prog_model.sv
// link programmer and firmware requester
`timescale 1ns/1ps
module obsrp_prog_model
  import obsrp_pkg::*;
(
  input  wire logic     mclk,
  input  wire obs_rsp_t dbgRsp,
  input  wire obs_rsp_t appRsp,
  output obs_req_t      dbgReq,
  output obs_req_t      appReq
);
  // both request buses start cleared, so no request is raised
  initial begin
    dbgReq = '0;
    appReq = '0;
  end
  // released lines show the inverse, not the old request
  task automatic acc(input logic d, input obs_req_t r,
                     output obs_rsp_t s);
    obs_req_t idle;
    idle = ~r;
    idle.req = 1'b0;
    @(posedge mclk);
    if (d) dbgReq <= r;
    else appReq <= r;
    @(posedge mclk);
    if (d) dbgReq <= idle;
    else appReq <= idle;
    @(posedge mclk);
    s = d ? dbgRsp : appRsp;
  endtask
endmodule

// file: tb.sv
// self-checking bench for the option byte store
`timescale 1ns/1ps
module tb;
  import obsrp_pkg::*;
  logic      mclk = 1'b0;
  logic      rst_n = 1'b0;
  logic      memWriteProtect = 1'b0;
  obs_req_t  dbgReq, appReq;
  obs_rsp_t  dbgRsp, appRsp;
  logic      memAccessBlock, readoutProtect, optLoaded;
  obs_opts_t appliedOpts;
  logic [NUM_PAIRS-1:0] optInvalid;
  int        n_errors = 0;
  int        comparisons = 0;
  always #20 mclk = ~mclk;
  obsrp_prog_model i_prog (.mclk, .dbgRsp, .appRsp, .dbgReq, .appReq);
  obsrp_option_store i_dut (.mclk, .rst_n, .dbgReq, .dbgRsp, .appReq,
    .appRsp, .memWriteProtect, .memAccessBlock, .readoutProtect,
    .appliedOpts, .optInvalid, .optLoaded);
  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic d, w, input logic [15:0] a,
                      input logic [7:0] wd, ed, input logic ee);
    obs_rsp_t r;
    i_prog.acc(d, '{1'b1, w, a, wd}, r);
    chk("valid", 8'h01, {7'h00, r.valid});
    chk("err", {7'h00, ee}, {7'h00, r.err});
    if (!w && !ee) chk("rdata", ed, r.rdata);
  endtask
  logic [15:0] ad [8] = '{ADDR_READOUT_PROTECT, ADDR_ALT_MUX_P2,
    ADDR_ALT_MUX_P2_INV, ADDR_MISC_OPT0, ADDR_MISC_OPT0_INV,
    ADDR_RESERVED_OPTION, ADDR_BOOTLOADER_TRUE, ADDR_BOOTLOADER_INV};
  logic [7:0]  fv [8] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00,
    8'h00, 8'hFF};
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10 && optLoaded !== 1'b1; i++) @(posedge mclk);
    if (optLoaded !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    chk("invalid", 8'h00, {5'h00, optInvalid});
    chk("block", 8'h00, {7'h00, memAccessBlock});
    chk("altMux", 8'h00, appliedOpts.altMuxP2);
    chk("misc", 8'h00, appliedOpts.miscOpt0);
    chk("boot", 8'h00, appliedOpts.bootOption);
    foreach (ad[i]) xfer(1, 0, ad[i], 8'h00, fv[i], 0);
    $display("test factory done");
    xfer(0, 1, ADDR_ALT_MUX_P2, 8'h5A, 8'h00, 0);
    xfer(0, 0, ADDR_ALT_MUX_P2, 8'h00, 8'h5A, 0);
    xfer(1, 1, ADDR_ALT_MUX_P2_INV, 8'hA5, 8'h00, 0);
    xfer(0, 0, ADDR_ALT_MUX_P2_INV, 8'h00, 8'hA5, 0);
    xfer(0, 1, ADDR_READOUT_PROTECT, 8'hAA, 8'h00, 1);
    xfer(1, 0, ADDR_READOUT_PROTECT, 8'h00, 8'h00, 0);
    @(posedge mclk) memWriteProtect <= 1'b1;
    xfer(0, 1, ADDR_MISC_OPT0, 8'h3C, 8'h00, 1);
    @(posedge mclk) memWriteProtect <= 1'b0;
    xfer(0, 0, ADDR_MISC_OPT0, 8'h00, 8'h00, 0);
    $display("test access done");
    xfer(1, 1, ADDR_READOUT_PROTECT, CODE_PROTECT_ON, 8'h00, 0);
    xfer(0, 0, ADDR_READOUT_PROTECT, 8'h00, CODE_PROTECT_ON, 0);
    chk("protect", 8'h01, {7'h00, readoutProtect});
    chk("block", 8'h01, {7'h00, memAccessBlock});
    xfer(1, 0, ADDR_ALT_MUX_P2, 8'h00, 8'h00, 1);
    xfer(1, 1, ADDR_MISC_OPT0, 8'h3C, 8'h00, 1);
    xfer(0, 0, ADDR_MISC_OPT0, 8'h00, 8'h00, 0);
    xfer(1, 1, ADDR_READOUT_PROTECT, 8'h00, 8'h00, 0);
    chk("protect", 8'h00, {7'h00, readoutProtect});
    chk("block", 8'h00, {7'h00, memAccessBlock});
    xfer(1, 0, ADDR_ALT_MUX_P2, 8'h00, 8'h5A, 0);
    xfer(1, 0, 16'h5000, 8'h00, 8'h00, 1);
    xfer(0, 0, 16'h3FFF, 8'h00, 8'h00, 1);
    xfer(1, 0, ADDR_EEPROM_LAST, 8'h00, 8'h00, 0);
    $display("test protect and region done");
    end_sim();
  end
endmodule
